// File: pkg/pgu_defines.svh
`ifndef PGU_DEFINES_SVH
`define PGU_DEFINES_SVH
// register select codes and register reset value of the user port bus
`define PGU_REG_OUT_HIGH_B   2'h0
`define PGU_REG_OUT_LOW_B    2'h1
`define PGU_REG_OUT_HIGH_A   2'h2
`define PGU_REG_INOUT_LOW_A  2'h3
`define PGU_REG_RESET        8'h00
// timing, read failure value, spare and amplifier counts
`define PGU_CLK_HZ           20000000
`define PGU_BUS_CYCLE_NS     500
`define PGU_READ_TOTAL_US    500
`define PGU_BUS_CYC ((`PGU_BUS_CYCLE_NS * (`PGU_CLK_HZ / 1000000) + 999) / 1000)
`define PGU_READ_CYC (`PGU_READ_TOTAL_US * (`PGU_CLK_HZ / 1000000))
`define PGU_READ_FAIL        16'hffff
`define PGU_LED_CYC          2000000
`define PGU_NSPARE           5
`define PGU_NAMP             4
`endif

// File: pkg/pgu_pkg.sv
package pgu_pkg;
  typedef enum logic [1:0] {
    PGU_CFG_UNLINKED = 2'b00,
    PGU_CFG_FULL     = 2'b01,
    PGU_CFG_OBS      = 2'b10,
    PGU_CFG_SINGLE   = 2'b11
  } pgu_cfg_t;

  typedef enum logic [1:0] {
    PGU_IDLE  = 2'b00,
    PGU_WRITE = 2'b01,
    PGU_READ  = 2'b10,
    PGU_HOLD  = 2'b11
  } pgu_state_t;

  // gating commands from the sequencer, each a one-cycle pulse
  typedef struct packed {
    logic [3:0] blank;
    logic [3:0] unblank;
    logic       rcv_off;
    logic       rcv_on;
    logic       pulse_start;
    logic       pulse_end;
    logic       acq_start;
    logic       acq_end;
  } pgu_gate_cmd_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        use_var;
    logic [1:0]  sel;
    logic [7:0]  imm;
    logic [15:0] var_val;
  } pgu_port_cmd_t;
endpackage : pgu_pkg

// File: src/pgu_top.sv
`include "pgu_defines.svh"
module pgu_top
  import pgu_pkg::*;
(
  input  wire logic          CLOCK,
  input  wire logic          NRST,
  input  wire pgu_cfg_t      CFG,
  input  wire pgu_gate_cmd_t GATE_CMD,
  input  wire logic          OBS_PULSING,
  input  wire logic [4:0]    SPARE_SET,
  input  wire logic [4:0]    SPARE_CLR,
  input  wire pgu_port_cmd_t PORT_CMD,
  input  wire logic [7:0]    GROUP_A_LOW_IN,
  input  wire logic          READ_ERROR,
  output logic [3:0]         AMP_UNBLANK,
  output logic               AMP_ENABLE,
  output logic               RCV_GATE,
  output logic [4:0]         SPARE_OUT,
  output logic [4:0]         SPARE_LED,
  output logic [15:0]        GROUP_A_OUT,
  output logic               GROUP_A_LOW_OE,
  output logic [15:0]        GROUP_B_OUT,
  output logic               PORT_BUSY,
  output logic               RD_DONE,
  output logic signed [15:0] RD_VALUE,
  output logic               HOST_WARN
);
  localparam int BUS_CYC  = `PGU_BUS_CYC;
  localparam int READ_CYC = `PGU_READ_CYC;
  localparam int LED_CYC  = `PGU_LED_CYC;

  // gating
  logic [3:0] unblank_q;
  logic       amp_en_q;
  logic       rcv_q;
  logic       rcv_off_latch_q;
  logic       acq_q;

  wire cfg_unl  = (CFG == PGU_CFG_UNLINKED);
  wire cfg_full = (CFG == PGU_CFG_FULL);
  wire cfg_obs  = (CFG == PGU_CFG_OBS);
  wire cfg_sgl  = (CFG == PGU_CFG_SINGLE);
  wire linked   = cfg_full | cfg_obs;
  wire sgl_blank   = |GATE_CMD.blank;
  wire sgl_unblank = |GATE_CMD.unblank;
  wire reenable = linked & GATE_CMD.pulse_end & ~(cfg_full & rcv_off_latch_q);

  logic [3:0] unblank_d;
  always_comb begin
    unblank_d = unblank_q;
    if (cfg_sgl) begin
      if (sgl_unblank) unblank_d = 4'hf;
      if (sgl_blank) unblank_d = 4'h0;
    end else begin
      unblank_d = (unblank_q & ~GATE_CMD.blank) | GATE_CMD.unblank;
      if (linked & GATE_CMD.pulse_end) unblank_d = cfg_obs ? {unblank_d[3:1], 1'b0} : 4'h0;
    end
  end

  logic rcv_d;
  always_comb begin
    rcv_d = rcv_q;
    if (GATE_CMD.rcv_off) rcv_d = 1'b0;
    if (GATE_CMD.rcv_on) rcv_d = 1'b1;
    if (cfg_obs & GATE_CMD.unblank[0]) rcv_d = 1'b0;
    if (cfg_obs & GATE_CMD.blank[0]) rcv_d = 1'b1;
    if (reenable) rcv_d = 1'b1;
    if (cfg_sgl & ~GATE_CMD.acq_start & ~acq_q) rcv_d = 1'b0;
    if (GATE_CMD.acq_start & ~cfg_unl) rcv_d = 1'b1;
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      unblank_q       <= 4'h0;
      amp_en_q        <= 1'b1;
      rcv_q           <= 1'b0;
      rcv_off_latch_q <= 1'b0;
      acq_q           <= 1'b0;
    end else begin
      unblank_q <= unblank_d;
      rcv_q     <= rcv_d;
      if (GATE_CMD.acq_start) acq_q <= 1'b1;
      else if (GATE_CMD.acq_end) acq_q <= 1'b0;
      // set wins: an explicit off in the same cycle as a clear stays latched
      if (GATE_CMD.rcv_off) rcv_off_latch_q <= 1'b1;
      else if (GATE_CMD.rcv_on) rcv_off_latch_q <= 1'b0;
      if (cfg_full & GATE_CMD.acq_start) amp_en_q <= 1'b0;
      else if (cfg_sgl & sgl_blank) amp_en_q <= 1'b0;
      else if ((cfg_sgl & sgl_unblank) | (cfg_full & |GATE_CMD.unblank)) amp_en_q <= 1'b1;
    end
  end

  // pulsing observe always blanks receiver, acquisition opens it while observe is not pulsing
  assign RCV_GATE    = (rcv_q | acq_q) & ~OBS_PULSING;
  assign AMP_UNBLANK = unblank_q;
  assign AMP_ENABLE  = amp_en_q;

  // spare lines and activity stretchers
  logic [4:0]  spare_q;
  logic [20:0] led_cnt_q [5];
  genvar gi;
  generate
    for (gi = 0; gi < `PGU_NSPARE; gi++) begin : g_spare
      wire act = SPARE_SET[gi] | SPARE_CLR[gi];
      always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
          spare_q[gi]   <= 1'b0;
          led_cnt_q[gi] <= 21'h0;
        end else begin
          if (SPARE_SET[gi]) spare_q[gi] <= 1'b1;
          else if (SPARE_CLR[gi]) spare_q[gi] <= 1'b0;
          // stretch so a short toggle is still visible
          if (act) led_cnt_q[gi] <= 21'(LED_CYC);
          else if (led_cnt_q[gi] != 21'h0) led_cnt_q[gi] <= led_cnt_q[gi] - 21'h1;
        end
      end
      assign SPARE_LED[gi] = (led_cnt_q[gi] != 21'h0);
    end
  endgenerate
  assign SPARE_OUT = spare_q;

  // user port bus
  logic [7:0]  ureg_q [4];
  pgu_state_t  st_q;
  logic [13:0] cnt_q;
  logic [1:0]  sel_q;
  logic [7:0]  wdat_q;
  logic        rd_done_q;
  logic        warn_q;
  logic [15:0] rd_val_q;

  wire        idle   = (st_q == PGU_IDLE);
  wire [7:0]  wr_val = PORT_CMD.use_var ? PORT_CMD.var_val[7:0] : PORT_CMD.imm;
  wire        cnt_end = (cnt_q == 14'h0);

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_q      <= PGU_IDLE;
      cnt_q     <= 14'h0;
      sel_q     <= 2'h0;
      wdat_q    <= 8'h00;
      rd_done_q <= 1'b0;
      warn_q    <= 1'b0;
      rd_val_q  <= 16'h0000;
      for (int i = 0; i < 4; i++) ureg_q[i] <= `PGU_REG_RESET;
    end else begin
      rd_done_q <= 1'b0;
      warn_q    <= 1'b0;
      case (st_q)
        PGU_IDLE: begin
          // commands are only taken while idle, in sequence order
          if (PORT_CMD.wr) begin
            st_q   <= PGU_WRITE;
            sel_q  <= PORT_CMD.sel;
            wdat_q <= wr_val;
            cnt_q  <= 14'(BUS_CYC - 1);
          end else if (PORT_CMD.rd) begin
            st_q <= PGU_READ;
          end
        end
        PGU_WRITE: begin
          if (cnt_end) begin
            ureg_q[sel_q] <= wdat_q;
            st_q <= PGU_IDLE;
          end else begin
            cnt_q <= cnt_q - 14'h1;
          end
        end
        PGU_READ: begin
          if (READ_ERROR) begin
            rd_val_q <= `PGU_READ_FAIL;
            warn_q   <= 1'b1;
          end else begin
            rd_val_q <= {8'h00, GROUP_A_LOW_IN};
          end
          cnt_q <= 14'(READ_CYC - 2);
          st_q  <= PGU_HOLD;
        end
        PGU_HOLD: begin
          // refill pause after sampling; total read time fixed
          if (cnt_end) begin
            rd_done_q <= 1'b1;
            st_q <= PGU_IDLE;
          end else begin
            cnt_q <= cnt_q - 14'h1;
          end
        end
        default: st_q <= PGU_IDLE;
      endcase
    end
  end

  assign GROUP_B_OUT    = {ureg_q[0], ureg_q[1]};
  assign GROUP_A_OUT    = {ureg_q[2], ureg_q[3]};
  assign GROUP_A_LOW_OE = 1'b1;
  assign PORT_BUSY      = ~idle;
  assign RD_DONE        = rd_done_q;
  assign RD_VALUE       = rd_val_q;
  assign HOST_WARN      = warn_q;

  // read age counter: the read window is far too long to unroll in a property
  logic [13:0] rd_age_q;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rd_age_q <= 14'h0;
    end else if (idle && PORT_CMD.rd && !PORT_CMD.wr) begin
      rd_age_q <= 14'h1;
    end else if (RD_DONE) begin
      rd_age_q <= 14'h0;
    end else if (rd_age_q != 14'h0 && rd_age_q != 14'h3fff) begin
      rd_age_q <= rd_age_q + 14'h1;
    end
  end

  // checks
  write_len_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (idle && PORT_CMD.wr) |=> (st_q == PGU_WRITE) [*8] ##1 (st_q == PGU_WRITE) [*2] ##1 idle);
  write_store_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (idle && PORT_CMD.wr && !PORT_CMD.use_var) |-> ##11 (ureg_q[$past(PORT_CMD.sel, 11)]
      == $past(PORT_CMD.imm, 11)));
  read_time_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    RD_DONE |-> (rd_age_q == 14'h2711));
  read_fail_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (st_q == PGU_READ && READ_ERROR) |=> (HOST_WARN && RD_VALUE == 16'hffff));
  read_val_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (st_q == PGU_READ && !READ_ERROR) |=> RD_VALUE == {8'h00, $past(GROUP_A_LOW_IN)});
  rcv_pulse_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    OBS_PULSING |-> !RCV_GATE);
  acq_rcv_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (GATE_CMD.acq_start && !cfg_unl && !OBS_PULSING) |=> (RCV_GATE || OBS_PULSING));
  full_amp_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (cfg_full && GATE_CMD.acq_start) |=> !AMP_ENABLE);
  suppress_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (cfg_full && rcv_off_latch_q && GATE_CMD.pulse_end && !GATE_CMD.rcv_on && !GATE_CMD.acq_start
     && !acq_q) |=> (rcv_q == ($past(rcv_q) && !$past(GATE_CMD.rcv_off))));
  relink_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (reenable && !GATE_CMD.acq_start) |=> (rcv_q && !AMP_UNBLANK[0]));
  spare_set_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    SPARE_SET[0] |=> SPARE_OUT[0] && SPARE_LED[0]);
  sgl_blank_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (cfg_sgl && sgl_blank) |=> (AMP_UNBLANK == 4'h0 && !AMP_ENABLE));

  read_busy_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (rd_age_q != 14'h0 && rd_age_q < 14'h2711) |->
    PORT_BUSY)
    else $error("read window ended early");
  read_done_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (rd_age_q == 14'h2711) |->
    RD_DONE)
    else $error("read done missing");
  write_hold_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (st_q == PGU_WRITE && !cnt_end) |=>
    (st_q == PGU_WRITE && $stable(sel_q) && $stable(wdat_q)))
    else $error("write changed while busy");
  port_hold_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    !(st_q == PGU_WRITE && cnt_end) |=>
    ($stable(GROUP_A_OUT) && $stable(GROUP_B_OUT)))
    else $error("user lines moved without write");
  map_b_high_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (st_q == PGU_WRITE && cnt_end && sel_q == 2'h0) |=>
    (GROUP_B_OUT[15:8] == $past(wdat_q)))
    else $error("register 0 mapped wrong");
  map_a_low_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (st_q == PGU_WRITE && cnt_end && sel_q == 2'h3) |=>
    (GROUP_A_OUT[7:0] == $past(wdat_q)))
    else $error("register 3 mapped wrong");
  var_form_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (idle && PORT_CMD.wr && PORT_CMD.use_var) |=>
    (wdat_q == $past(PORT_CMD.var_val[7:0])))
    else $error("variable write value wrong");
  spare_clr_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (SPARE_CLR[0] && !SPARE_SET[0]) |=>
    !SPARE_OUT[0])
    else $error("spare line not cleared");
  spare_hold_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (SPARE_SET == 5'h00 && SPARE_CLR == 5'h00) |=>
    $stable(SPARE_OUT))
    else $error("spare line moved without command");
  unl_indep_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (cfg_unl && GATE_CMD.unblank[1] && !GATE_CMD.blank[1]) |=>
    AMP_UNBLANK[1])
    else $error("decoupler unblank lost");
  unl_rcv_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (cfg_unl && !GATE_CMD.rcv_off && !GATE_CMD.rcv_on) |=>
    $stable(rcv_q))
    else $error("receiver moved without command");
  obs_link_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (cfg_obs && GATE_CMD.unblank[0] && !GATE_CMD.blank[0] && !reenable && !GATE_CMD.acq_start) |=>
    !rcv_q)
    else $error("observe unblank left receiver on");
  obs_dec_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (cfg_obs && GATE_CMD.unblank[2] && !GATE_CMD.blank[2]) |=>
    AMP_UNBLANK[2])
    else $error("decoupler unblank lost in observe link");
  sgl_rcv_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (cfg_sgl && !GATE_CMD.acq_start && !acq_q) |=>
    !rcv_q)
    else $error("receiver on outside acquisition");
  full_unblank_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (cfg_full && GATE_CMD.unblank[0] && !GATE_CMD.acq_start) |=>
    AMP_ENABLE)
    else $error("amplifier not switched on");
  acq_open_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (acq_q && !OBS_PULSING) |->
    RCV_GATE)
    else $error("receiver closed in acquisition");
  led_stretch_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (led_cnt_q[0] > 21'h1) |=>
    SPARE_LED[0])
    else $error("activity indicator dropped early");
  warn_pulse_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    HOST_WARN |=>
    !HOST_WARN)
    else $error("warning longer than one cycle");

  write_cov: cover property (@(posedge CLOCK) disable iff (!NRST) st_q == PGU_WRITE ##1 idle);
  read_cov: cover property (@(posedge CLOCK) disable iff (!NRST) RD_DONE);
  warn_cov: cover property (@(posedge CLOCK) disable iff (!NRST) HOST_WARN);
  spare_cov: cover property (@(posedge CLOCK) disable iff (!NRST) SPARE_LED[0] && !SPARE_OUT[0]);
  supp_cov: cover property (@(posedge CLOCK) disable iff (!NRST)
    cfg_full && rcv_off_latch_q && GATE_CMD.pulse_end);
endmodule : pgu_top

// File: tb/pgu_user_equip.sv
module pgu_user_equip (
  input  wire logic       CLOCK,
  input  wire logic [7:0] PATTERN,
  input  wire logic       FAIL,
  output logic [7:0]      LINES = 8'h00,
  output logic            ERR   = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // equipment only moves its lines away from the sampling edge
  always @(negedge CLOCK) begin
    LINES <= PATTERN;
    ERR   <= FAIL;
  end
endmodule : pgu_user_equip

// File: tb/pulse_gating_user_port_test.sv
module pulse_gating_user_port_test;
  import pgu_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, obs = 0, fail = 0, busy_q = 0;
  pgu_cfg_t      cfg = PGU_CFG_UNLINKED;
  pgu_gate_cmd_t gc  = '0;
  pgu_port_cmd_t pc  = '0;
  logic [4:0]  sset = '0, sclr = '0, sout, led;
  logic [7:0]  pat = 8'h00, lin;
  logic        err, busy, rdd, warn, rcv, amp_en, oe;
  logic [3:0]  unb;
  logic [15:0] ga, gb;
  logic signed [15:0] rdv;
  logic [7:0]  regs[4] = '{default: 8'h00};
  logic [31:0] grp_q[$];
  logic [15:0] rd_q[$];
  logic [31:0] rs = 32'd74;
  int num_errors = 0, n_checks = 0, nwarn = 0;

  always #25 clk = ~clk;

  pgu_user_equip eq (.CLOCK(clk), .PATTERN(pat), .FAIL(fail), .LINES(lin), .ERR(err));
  pgu_top dut (.CLOCK(clk), .NRST(nrst), .CFG(cfg), .GATE_CMD(gc), .OBS_PULSING(obs),
    .SPARE_SET(sset), .SPARE_CLR(sclr), .PORT_CMD(pc), .GROUP_A_LOW_IN(lin),
    .READ_ERROR(err), .AMP_UNBLANK(unb), .AMP_ENABLE(amp_en), .RCV_GATE(rcv),
    .SPARE_OUT(sout), .SPARE_LED(led), .GROUP_A_OUT(ga), .GROUP_A_LOW_OE(oe),
    .GROUP_B_OUT(gb), .PORT_BUSY(busy), .RD_DONE(rdd), .RD_VALUE(rdv), .HOST_WARN(warn));

  function logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction : rnd

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task rst(input pgu_cfg_t c);
    nrst = 0;
    cfg  = c;
    repeat (5) @(negedge clk);
    nrst = 1;
  endtask : rst

  task gate(input pgu_gate_cmd_t c);
    gc = c;
    @(negedge clk);
    gc = '0;
  endtask : gate

  // immediate and variable forms carry a decoy in the unused field
  task port(input logic rd, input logic [1:0] sel, input logic [7:0] v, input logic uv);
    int i;
    pc = '{wr: !rd, rd: rd, use_var: uv, sel: sel, imm: uv ? ~v : v,
           var_val: uv ? {8'h5a, v} : {8'h00, ~v}};
    if (!rd) regs[sel] = v;
    grp_q.push_back({regs[2], regs[3], regs[0], regs[1]});
    if (rd) rd_q.push_back(fail ? 16'hffff : {8'h00, pat});
    @(negedge clk);
    pc.wr = 0;
    pc.rd = 0;
    i = 0;
    while (busy !== 1'b0 && i < 20000) begin
      @(negedge clk);
      i++;
    end
    check(i, rd ? 32'h2710 : 32'ha);
  endtask : port

  always @(negedge clk) begin
    busy_q <= busy;
    if (warn === 1'b1) nwarn++;
    if (busy_q === 1'b1 && busy === 1'b0 && grp_q.size() > 0)
      check({ga, gb}, grp_q.pop_front());
    if (rdd === 1'b1 && rd_q.size() > 0)
      check({16'h0, rdv}, {16'h0, rd_q.pop_front()});
  end

  initial begin
    #4000000;
    num_errors++;
    give_verdict();
  end

  initial begin
    pgu_gate_cmd_t c;
    rst(PGU_CFG_UNLINKED);
    for (int k = 0; k < 8; k++) port(0, k[1:0], rnd(), k[2]);
    pat = rnd();
    @(negedge clk);
    port(1, 2'h3, 8'h00, 0);
    repeat (20) @(negedge clk);
    fail = 1;
    @(negedge clk);
    port(1, 2'h3, 8'h00, 0);
    repeat (20) @(negedge clk);
    fail = 0;
    check(nwarn, 32'h1);
    check(oe, 32'h1);
    sset = 5'h11;
    @(negedge clk);
    sset = 5'h00;
    check({led, sout}, {5'h11, 5'h11});
    sclr = 5'h01;
    @(negedge clk);
    sclr = 5'h00;
    check(sout, 5'h10);
    c = '0;
    c.unblank = 4'h4;
    gate(c);
    check({unb, rcv}, {4'h4, 1'b0});
    c = '0;
    c.rcv_on = 1;
    gate(c);
    check({unb, rcv}, {4'h4, 1'b1});
    obs = 1;
    #1 check(rcv, 32'h0);
    obs = 0;
    rst(PGU_CFG_FULL);
    c = '0;
    c.unblank = 4'h1;
    gate(c);
    c = '0;
    c.pulse_end = 1;
    gate(c);
    check({unb, rcv}, {4'h0, 1'b1});
    c = '0;
    c.rcv_off = 1;
    gate(c);
    c = '0;
    c.pulse_end = 1;
    gate(c);
    check(rcv, 32'h0);
    c = '0;
    c.acq_start = 1;
    gate(c);
    check({amp_en, rcv}, 32'h1);
    give_verdict();
  end
endmodule : pulse_gating_user_port_test
